// ---- qpa_pkg.sv ----
// constants, types and register map of the qos priority source assign block
// Functional notes
// - ctrl bit 11 remaps port priority
// - per-port choice: 0 inner dei0, 1 outer dei0
// - acl hit gives acl priority, else null
// - ip only: tos upper six bits lookup
// - ipv6 traffic class treated as tos
// - invalid codepoint match forces null when enabled
// - inner tag remapped by dei table, else null
// - outer tag remapped by dei table, else null
// - tag map entries hold 3-bit priority
// - route hit with assign flag gives priority
// - mac/subnet vlan hit gives entry priority
// - bit 9 remaps it by vlan kind
// - tag dei picks table, untagged dei0
// - proto-port vlan hit gives entry priority
// - bit 10 remaps proto-port priority likewise
// - etag pcp and dei remapped, else null
// - tunnel hit: capwap bssid, else entry priority
// - tunnel hit supplies selection table index
// - mpls hit assign 1 uses entry priority
// - mpls assign 0 remaps tc, else null
// - per-port 3-bit port priority register
package qpa_pkg;
    localparam int PRIO_W = 3;
    localparam int NUM_PORTS = 8;
    localparam int PORT_W = 3;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int DSCP_W = 6;
    localparam int TOS_W = 8;
    localparam int SEL_IDX_W = 2;
    localparam int MAP_DEPTH = 128;
    localparam int MAP_IDX_W = 7;
    localparam logic [MAP_IDX_W-1:0] MAP_USED = 7'h78;
    // entry bases inside the shared map store
    localparam logic [MAP_IDX_W-1:0] MAP_DSCP_BASE = 7'h00;
    localparam logic [MAP_IDX_W-1:0] MAP_IN0_BASE = 7'h40;
    localparam logic [MAP_IDX_W-1:0] MAP_IN1_BASE = 7'h48;
    localparam logic [MAP_IDX_W-1:0] MAP_OUT0_BASE = 7'h50;
    localparam logic [MAP_IDX_W-1:0] MAP_OUT1_BASE = 7'h58;
    localparam logic [MAP_IDX_W-1:0] MAP_ETAG_BASE = 7'h60;
    localparam logic [MAP_IDX_W-1:0] MAP_MPLS_BASE = 7'h70;
    // byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] PORT_PRIO_OFS = 12'h100;
    localparam logic [ADDR_W-1:0] PORT_CHOICE_OFS = 12'h140;
    localparam logic [ADDR_W-1:0] MAP_OFS = 12'h200;
    localparam int WORD_LSB = 2;
    localparam int PORT_BLK_LSB = 5;
    localparam int MAP_BLK_LSB = 9;
    // control fields
    localparam int CTRL_PORT_REMAP_BIT = 11;
    localparam int CTRL_PROTO_REMAP_BIT = 10;
    localparam int CTRL_MACV_REMAP_BIT = 9;
    localparam int CTRL_INV_EN_BIT = 8;
    localparam int CTRL_INV_HI = 5;
    localparam int CTRL_INV_LO = 0;
    localparam int CTRL_W = 12;
    localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
    localparam logic [CTRL_W-1:0] CTRL_MASK = 12'hF3F;
    localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;

    typedef struct packed {
        logic valid;
        logic [PRIO_W-1:0] prio;
    } qpa_cand_type;

    typedef struct packed {
        logic valid;
        logic [PORT_W-1:0] rx_port;
        logic acl_hit;
        logic [PRIO_W-1:0] acl_prio;
        logic is_ipv4;
        logic is_ipv6;
        logic [TOS_W-1:0] tos;
        logic itag_present;
        logic itag_dei;
        logic [PRIO_W-1:0] itag_pri;
        logic otag_present;
        logic otag_dei;
        logic [PRIO_W-1:0] otag_pri;
        logic route_hit;
        logic route_assign;
        logic [PRIO_W-1:0] route_prio;
        logic macv_hit;
        logic macv_outer;
        logic [PRIO_W-1:0] macv_prio;
        logic proto_hit;
        logic proto_outer;
        logic [PRIO_W-1:0] proto_prio;
        logic etag_present;
        logic etag_dei;
        logic [PRIO_W-1:0] etag_pcp;
        logic tt_hit;
        logic tt_capwap;
        logic [PRIO_W-1:0] bssid_prio;
        logic [PRIO_W-1:0] tt_prio;
        logic [SEL_IDX_W-1:0] tt_sel_idx;
        logic mpls_hit;
        logic mpls_assign;
        logic [PRIO_W-1:0] mpls_prio;
        logic [PRIO_W-1:0] mpls_tc;
    } qpa_pkt_type;

    typedef struct packed {
        logic valid;
        qpa_cand_type port;
        qpa_cand_type acl;
        qpa_cand_type dscp;
        qpa_cand_type itag;
        qpa_cand_type otag;
        qpa_cand_type route;
        qpa_cand_type macv;
        qpa_cand_type proto;
        qpa_cand_type etag;
        qpa_cand_type tunnel;
        qpa_cand_type mpls;
        logic tt_idx_valid;
        logic [SEL_IDX_W-1:0] tt_idx;
    } qpa_res_type;

    typedef struct packed {
        logic we;
        logic [MAP_IDX_W-1:0] idx;
        logic [PRIO_W-1:0] data;
    } qpa_wr_type;

    typedef logic [MAP_DEPTH-1:0][PRIO_W-1:0] qpa_map_type;
endpackage

// ---- qpa_map_store.sv ----
// flip-flop store of all priority remap tables
`timescale 1ns/1ps
module qpa_map_store (
    input wire logic clk,
    input wire logic nrst,
    input qpa_pkg::qpa_wr_type wr,
    output qpa_pkg::qpa_map_type map
);
    typedef struct packed {
        qpa_pkg::qpa_map_type ent;
    } qpa_store_type;

    qpa_store_type s_r;
    qpa_store_type s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (wr.we)
        begin
            s_nxt.ent[wr.idx] = wr.data;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign map = s_r.ent;
endmodule

// ---- qpa_top.sv ----
// priority source assignment with apb register file
`timescale 1ns/1ps
module qpa_top (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [qpa_pkg::ADDR_W-1:0] PADDR,
    input wire logic [qpa_pkg::DATA_W-1:0] PWDATA,
    output logic [qpa_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input qpa_pkg::qpa_pkt_type PKT_IN,
    output qpa_pkg::qpa_res_type PRIO_OUT
);
    typedef logic [qpa_pkg::PRIO_W-1:0] qpa_prio_type;

    typedef struct packed {
        logic [qpa_pkg::CTRL_W-1:0] ctrl;
        logic [qpa_pkg::NUM_PORTS-1:0][qpa_pkg::PRIO_W-1:0] port_prio;
        logic [qpa_pkg::NUM_PORTS-1:0] port_choice;
        logic [qpa_pkg::DATA_W-1:0] rdata;
        logic slverr;
        qpa_pkg::qpa_res_type res;
    } qpa_state_type;

    qpa_state_type s_r;
    qpa_state_type s_nxt;
    qpa_pkg::qpa_map_type map;
    qpa_pkg::qpa_wr_type map_wr;

    qpa_map_store u_store (
        .clk(REF_CLK),
        .nrst(NRST),
        .wr(map_wr),
        .map(map)
    );

    // tag remap: outer picks the outer pair, dei picks the table
    function automatic qpa_prio_type remap(
        input qpa_pkg::qpa_map_type m,
        input logic outer,
        input logic dei,
        input qpa_prio_type vlan_entry_prio
    );
        logic [qpa_pkg::MAP_IDX_W-1:0] base;
        if (outer)
        begin
            base = dei ? qpa_pkg::MAP_OUT1_BASE : qpa_pkg::MAP_OUT0_BASE;
        end
        else
        begin
            base = dei ? qpa_pkg::MAP_IN1_BASE : qpa_pkg::MAP_IN0_BASE;
        end
        return m[base + qpa_pkg::MAP_IDX_W'(vlan_entry_prio)];
    endfunction

    // vlan entry priority, optionally treated as a tag priority
    function automatic qpa_prio_type vlan_prio(
        input qpa_pkg::qpa_map_type m,
        input logic en,
        input logic outer,
        input qpa_prio_type vlan_entry_prio,
        input qpa_pkg::qpa_pkt_type p
    );
        logic dei;
        // untagged packets always use the dei 0 table
        if (outer)
        begin
            dei = p.otag_present & p.otag_dei;
        end
        else
        begin
            dei = p.itag_present & p.itag_dei;
        end
        if (en)
        begin
            return remap(m, outer, dei, vlan_entry_prio);
        end
        return vlan_entry_prio;
    endfunction

    logic apb_setup;
    logic apb_access;
    logic ctrl_hit;
    logic pprio_hit;
    logic pchoice_hit;
    logic map_hit;
    logic any_hit;
    logic [qpa_pkg::PORT_W-1:0] port_sel;
    logic [qpa_pkg::MAP_IDX_W-1:0] map_sel;
    logic [qpa_pkg::DSCP_W-1:0] dscp;
    logic inv_match;
    logic [qpa_pkg::DATA_W-1:0] rd_mux;
    qpa_pkg::qpa_res_type r;
    qpa_prio_type pp;

    always_comb
    begin
        apb_setup = PSEL & ~PENABLE;
        apb_access = PSEL & PENABLE;
        port_sel = PADDR[qpa_pkg::WORD_LSB +: qpa_pkg::PORT_W];
        map_sel = PADDR[qpa_pkg::WORD_LSB +: qpa_pkg::MAP_IDX_W];
        ctrl_hit = PADDR[qpa_pkg::ADDR_W-1:qpa_pkg::WORD_LSB]
            == qpa_pkg::CTRL_OFS[qpa_pkg::ADDR_W-1:qpa_pkg::WORD_LSB];
        pprio_hit = PADDR[qpa_pkg::ADDR_W-1:qpa_pkg::PORT_BLK_LSB]
            == qpa_pkg::PORT_PRIO_OFS[qpa_pkg::ADDR_W-1:
                qpa_pkg::PORT_BLK_LSB];
        pchoice_hit = PADDR[qpa_pkg::ADDR_W-1:qpa_pkg::PORT_BLK_LSB]
            == qpa_pkg::PORT_CHOICE_OFS[qpa_pkg::ADDR_W-1:
                qpa_pkg::PORT_BLK_LSB];
        // top slots of the store are spare and answer as unmapped
        map_hit = (PADDR[qpa_pkg::ADDR_W-1:qpa_pkg::MAP_BLK_LSB]
            == qpa_pkg::MAP_OFS[qpa_pkg::ADDR_W-1:qpa_pkg::MAP_BLK_LSB])
            && (map_sel < qpa_pkg::MAP_USED);
        any_hit = ctrl_hit | pprio_hit | pchoice_hit | map_hit;

        rd_mux = '0;
        if (ctrl_hit)
        begin
            rd_mux[qpa_pkg::CTRL_W-1:0] = s_r.ctrl;
        end
        else if (pprio_hit)
        begin
            rd_mux[qpa_pkg::PRIO_W-1:0] = s_r.port_prio[port_sel];
        end
        else if (pchoice_hit)
        begin
            rd_mux[0] = s_r.port_choice[port_sel];
        end
        else if (map_hit)
        begin
            rd_mux[qpa_pkg::PRIO_W-1:0] = map[map_sel];
        end

        map_wr.we = apb_access & PWRITE & map_hit;
        map_wr.idx = map_sel;
        map_wr.data = PWDATA[qpa_pkg::PRIO_W-1:0];

        s_nxt = s_r;
        // read data and error are caught in setup so they leave a flop
        if (apb_setup)
        begin
            s_nxt.rdata = PWRITE ? '0 : rd_mux;
            s_nxt.slverr = ~any_hit;
        end
        if (apb_access & PWRITE)
        begin
            if (ctrl_hit)
            begin
                s_nxt.ctrl = PWDATA[qpa_pkg::CTRL_W-1:0]
                    & qpa_pkg::CTRL_MASK;
            end
            if (pprio_hit)
            begin
                s_nxt.port_prio[port_sel] =
                    PWDATA[qpa_pkg::PRIO_W-1:0];
            end
            if (pchoice_hit)
            begin
                s_nxt.port_choice[port_sel] = PWDATA[0];
            end
        end

        // candidate computation, one cycle of latency
        r = '0;
        r.valid = PKT_IN.valid;
        pp = s_r.port_prio[PKT_IN.rx_port];
        if (s_r.ctrl[qpa_pkg::CTRL_PORT_REMAP_BIT])
        begin
            // port priority is looked up as if it were a dei 0 tag
            pp = remap(map, s_r.port_choice[PKT_IN.rx_port], 1'b0,
                pp);
        end
        r.port.valid = 1'b1;
        r.port.prio = pp;

        r.acl.valid = PKT_IN.acl_hit;
        r.acl.prio = PKT_IN.acl_prio;

        // ipv6 traffic class sits in the same byte slot as tos
        dscp = PKT_IN.tos[qpa_pkg::TOS_W-1 -: qpa_pkg::DSCP_W];
        inv_match = s_r.ctrl[qpa_pkg::CTRL_INV_EN_BIT]
            && (dscp == s_r.ctrl[qpa_pkg::CTRL_INV_HI:
                qpa_pkg::CTRL_INV_LO]);
        r.dscp.valid = (PKT_IN.is_ipv4 | PKT_IN.is_ipv6)
            & ~inv_match;
        r.dscp.prio = map[qpa_pkg::MAP_DSCP_BASE
            + qpa_pkg::MAP_IDX_W'(dscp)];

        r.itag.valid = PKT_IN.itag_present;
        r.itag.prio = remap(map, 1'b0, PKT_IN.itag_dei,
            PKT_IN.itag_pri);
        r.otag.valid = PKT_IN.otag_present;
        r.otag.prio = remap(map, 1'b1, PKT_IN.otag_dei,
            PKT_IN.otag_pri);

        r.route.valid = PKT_IN.route_hit
            & PKT_IN.route_assign;
        r.route.prio = PKT_IN.route_prio;

        r.macv.valid = PKT_IN.macv_hit;
        r.macv.prio = vlan_prio(map,
            s_r.ctrl[qpa_pkg::CTRL_MACV_REMAP_BIT],
            PKT_IN.macv_outer, PKT_IN.macv_prio, PKT_IN);

        r.proto.valid = PKT_IN.proto_hit;
        r.proto.prio = vlan_prio(map,
            s_r.ctrl[qpa_pkg::CTRL_PROTO_REMAP_BIT],
            PKT_IN.proto_outer, PKT_IN.proto_prio, PKT_IN);

        r.etag.valid = PKT_IN.etag_present;
        r.etag.prio = map[qpa_pkg::MAP_ETAG_BASE + qpa_pkg::MAP_IDX_W'(
            {PKT_IN.etag_dei, PKT_IN.etag_pcp})];

        r.tunnel.valid = PKT_IN.tt_hit;
        r.tunnel.prio = PKT_IN.tt_capwap ? PKT_IN.bssid_prio
            : PKT_IN.tt_prio;
        r.tt_idx_valid = PKT_IN.tt_hit;
        r.tt_idx = PKT_IN.tt_sel_idx;

        r.mpls.valid = PKT_IN.mpls_hit;
        r.mpls.prio = PKT_IN.mpls_assign ? PKT_IN.mpls_prio
            : map[qpa_pkg::MAP_MPLS_BASE
                + qpa_pkg::MAP_IDX_W'(PKT_IN.mpls_tc)];

        // null sources carry zero so stale values never leak
        if (!r.acl.valid) r.acl.prio = qpa_pkg::PRIO_RST;
        if (!r.dscp.valid) r.dscp.prio = qpa_pkg::PRIO_RST;
        if (!r.itag.valid) r.itag.prio = qpa_pkg::PRIO_RST;
        if (!r.otag.valid) r.otag.prio = qpa_pkg::PRIO_RST;
        if (!r.route.valid) r.route.prio = qpa_pkg::PRIO_RST;
        if (!r.macv.valid) r.macv.prio = qpa_pkg::PRIO_RST;
        if (!r.proto.valid) r.proto.prio = qpa_pkg::PRIO_RST;
        if (!r.etag.valid) r.etag.prio = qpa_pkg::PRIO_RST;
        if (!r.tunnel.valid) r.tunnel.prio = qpa_pkg::PRIO_RST;
        if (!r.mpls.valid) r.mpls.prio = qpa_pkg::PRIO_RST;
        if (!r.tt_idx_valid) r.tt_idx = '0;
        // a gap in the packet stream gives an all-null result
        if (!PKT_IN.valid)
        begin
            r = '0;
        end
        s_nxt.res = r;
    end

    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            s_r <= '0;
            s_r.ctrl <= qpa_pkg::CTRL_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // zero wait states: data was prepared during the setup cycle
    assign PREADY = apb_access;
    assign PRDATA = s_r.rdata;
    assign PSLVERR = s_r.slverr & apb_access;
    assign PRIO_OUT = s_r.res;
endmodule

// ---- qpa_parser_model.sv ----
// parser stand-in: presents one packet descriptor per request
`timescale 1ns/1ps
module qpa_parser_model (
    input wire logic clk,
    input wire logic nrst,
    input qpa_pkg::qpa_pkt_type req,
    output qpa_pkg::qpa_pkt_type pkt
);
    // fields toggle between packets so a stale read cannot pass
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pkt <= '0;
        else if (req.valid)
            pkt <= req;
        else
            pkt <= {1'b0, ~pkt[$bits(pkt)-2:0]};
    end
endmodule

// ---- qpa_chk.sv ----
// concurrent checks on the priority source outputs
`timescale 1ns/1ps
module qpa_chk (
    input wire logic REF_CLK,
    input wire logic NRST,
    input qpa_pkg::qpa_pkt_type PKT_IN,
    input qpa_pkg::qpa_res_type PRIO_OUT
);
    default clocking dc @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);
    sequence s_pkt;
        PKT_IN.valid;
    endsequence
    sequence s_tt;
        PKT_IN.valid && PKT_IN.tt_hit;
    endsequence
    AST_PORT_VALID: assert property (
        s_pkt |=> PRIO_OUT.port.valid)
        else $error("port source missing");
    AST_IDLE_NULL: assert property (
        !PKT_IN.valid |=> PRIO_OUT == '0)
        else $error("result without packet");
    AST_ACL: assert property (
        s_pkt |=> PRIO_OUT.acl == ($past(PKT_IN.acl_hit) ?
        {1'b1, $past(PKT_IN.acl_prio)} : 4'h0))
        else $error("acl source wrong");
    AST_ROUTE: assert property (
        s_pkt |=> PRIO_OUT.route.valid ==
        $past(PKT_IN.route_hit && PKT_IN.route_assign))
        else $error("route source wrong");
    AST_NON_IP: assert property (
        s_pkt ##0 !(PKT_IN.is_ipv4 || PKT_IN.is_ipv6)
        |=> !PRIO_OUT.dscp.valid)
        else $error("codepoint source on non ip");
    AST_ITAG_NULL: assert property (
        s_pkt ##0 !PKT_IN.itag_present |=> !PRIO_OUT.itag.valid)
        else $error("inner source without tag");
    AST_MACV_HIT: assert property (
        s_pkt |=> PRIO_OUT.macv.valid == $past(PKT_IN.macv_hit))
        else $error("mac vlan source wrong");
    AST_TUNNEL: assert property (
        s_tt |=> PRIO_OUT.tunnel.valid && PRIO_OUT.tunnel.prio ==
        ($past(PKT_IN.tt_capwap) ? $past(PKT_IN.bssid_prio)
        : $past(PKT_IN.tt_prio)))
        else $error("tunnel source wrong");
    AST_MPLS: assert property (
        s_pkt ##0 PKT_IN.mpls_hit && PKT_IN.mpls_assign
        |=> PRIO_OUT.mpls == {1'b1, $past(PKT_IN.mpls_prio)})
        else $error("mpls source wrong");
endmodule
bind qpa_top qpa_chk u_chk (
    .REF_CLK(REF_CLK),
    .NRST(NRST),
    .PKT_IN(PKT_IN),
    .PRIO_OUT(PRIO_OUT)
);

// ---- tb_qos_priority_source_assign.sv ----
// self-checking bench for the priority source assignment block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_qos_priority_source_assign;
    logic ref_clk;
    logic nrst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [qpa_pkg::ADDR_W-1:0] paddr;
    logic [qpa_pkg::DATA_W-1:0] pwdata;
    logic [qpa_pkg::DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic err;
    logic [31:0] rd;
    qpa_pkg::qpa_pkt_type req;
    qpa_pkg::qpa_pkt_type pkt_in;
    qpa_pkg::qpa_pkt_type p;
    qpa_pkg::qpa_res_type r;
    int failures;
    int tests_run;
    qpa_parser_model u_src (
        .clk(ref_clk),
        .nrst(nrst),
        .req(req),
        .pkt(pkt_in)
    );
    qpa_top uut (
        .REF_CLK(ref_clk),
        .NRST(nrst),
        .PSEL(psel),
        .PENABLE(penable),
        .PWRITE(pwrite),
        .PADDR(paddr),
        .PWDATA(pwdata),
        .PRDATA(prdata),
        .PREADY(pready),
        .PSLVERR(pslverr),
        .PKT_IN(pkt_in),
        .PRIO_OUT(r)
    );
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [2:0] mv(input int i);
        return 3'(i * 5 + 3);
    endfunction
    function automatic logic [3:0] c(input bit v, input int x);
        return v ? {1'b1, 3'(x)} : 4'h0;
    endfunction
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // one packet through the parser stage, result one edge later
    task automatic go();
        @(posedge ref_clk);
        req <= p;
        @(posedge ref_clk);
        req.valid <= 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK(r.valid, 1'b1)
    endtask
    task automatic t_regs();
        apb(1'b0, qpa_pkg::CTRL_OFS, '0);
        `CHK(rd, 32'h0000_0000)
        wr(qpa_pkg::CTRL_OFS, 32'hFFFF_FFFF);
        apb(1'b0, qpa_pkg::CTRL_OFS, '0);
        `CHK(rd, 32'h0000_0F3F)
        apb(1'b0, 12'h3E0, '0);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
    endtask
    task automatic t_port();
        for (int i = 0; i < 120; i++)
            wr(qpa_pkg::MAP_OFS + 12'(4 * i), 32'(mv(i)));
        wr(12'h108, 32'h0000_000E);
        apb(1'b0, 12'h108, '0);
        `CHK({err, rd}, {1'b0, 32'h0000_0006})
        p = '0;
        p.valid = 1'b1;
        p.rx_port = 3'h2;
        for (int k = 0; k < 4; k++)
        begin
            wr(qpa_pkg::CTRL_OFS, k[1] ? 32'h0000_0800 : 32'h0000_0000);
            wr(12'h148, 32'(k % 2));
            go();
            `CHK(r.port, c(1, k < 2 ? 6 : mv((k % 2 ? 80 : 64) + 6)))
        end
    endtask
    task automatic t_dscp();
        wr(qpa_pkg::CTRL_OFS, 32'h0000_0000);
        p.tos = 8'hB4;
        for (int k = 0; k < 5; k++)
        begin
            p.is_ipv4 = k == 1;
            p.is_ipv6 = k >= 2;
            // value 45 is this packet's codepoint, 44 is not
            if (k >= 3)
                wr(qpa_pkg::CTRL_OFS, k == 3 ? 32'h0000_012D : 32'h0000_012C);
            go();
            `CHK(r.dscp, c(k != 0 && k != 3, mv(45)))
        end
        wr(qpa_pkg::CTRL_OFS, 32'h0000_0000);
    endtask
    task automatic t_tags();
        for (int k = 0; k < 18; k++)
        begin
            p.itag_present = k < 16;
            p.otag_present = k < 16;
            p.itag_dei = 1'(k / 8);
            p.itag_pri = 3'(k);
            p.otag_dei = 1'(1 - k / 8);
            p.otag_pri = 3'(7 - k % 8);
            go();
            `CHK(r.itag, c(k < 16, mv(64 + 8 * (k / 8) + k % 8)))
            `CHK(r.otag, c(k < 16, mv(87 + 8 * (1 - k / 8) - k % 8)))
        end
    endtask
    task automatic t_vlan();
        int o;
        int d;
        int e;
        for (int k = 0; k < 17; k++)
        begin
            o = k % 2;
            d = (k / 4) % 2 ? (k / 2) % 2 : 0;
            e = (k / 8) % 2;
            if (k == 8)
                wr(qpa_pkg::CTRL_OFS, 32'h0000_0600);
            p.macv_hit = k < 16;
            p.proto_hit = k < 16;
            p.macv_outer = 1'(o);
            p.proto_outer = 1'(1 - o);
            p.itag_present = 1'((k / 4) % 2);
            p.otag_present = 1'((k / 4) % 2);
            p.itag_dei = 1'((k / 2) % 2);
            p.otag_dei = 1'((k / 2) % 2);
            p.macv_prio = 3'h5;
            p.proto_prio = 3'h2;
            go();
            `CHK(r.macv, c(k < 16, e ? mv(16*o + 69 + 8*d) : 5))
            `CHK(r.proto, c(k < 16, e ? mv(82 - o * 16 + 8 * d) : 2))
        end
        wr(qpa_pkg::CTRL_OFS, 32'h0000_0000);
    endtask
    task automatic t_misc();
        int m;
        for (int k = 0; k < 17; k++)
        begin
            m = k % 3;
            p.acl_hit = 1'(k % 2);
            p.acl_prio = 3'(k);
            p.route_hit = m != 0;
            p.route_assign = 1'(k % 2);
            p.route_prio = 3'(k * 3);
            p.etag_present = k < 16;
            p.etag_dei = 1'(k / 8);
            p.etag_pcp = 3'(k);
            p.tt_hit = k % 4 != 0;
            p.tt_capwap = 1'(k % 2);
            p.bssid_prio = 3'(k + 1);
            p.tt_prio = 3'(k + 2);
            p.tt_sel_idx = 2'(k + 1);
            p.mpls_hit = m != 0;
            p.mpls_assign = m == 1;
            p.mpls_prio = 3'(k + 3);
            p.mpls_tc = 3'(k);
            go();
            `CHK(r.acl, c(k % 2, k))
            `CHK(r.route, c(m != 0 && k % 2, k * 3))
            `CHK(r.etag, c(k < 16, mv(96 + k)))
            `CHK(r.tunnel, c(k % 4 != 0, k + 1 + (1 - k % 2)))
            `CHK(r.tt_idx_valid, k % 4 != 0)
            if (k % 4 != 0)
                `CHK(r.tt_idx, 2'(k + 1))
            `CHK(r.mpls, c(m != 0, m == 1 ? k + 3 : mv(112 + k % 8)))
        end
    endtask
    task automatic results();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        failures++;
        results();
    end
    initial
    begin
        failures = 0;
        tests_run = 0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        req = '0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs();
        t_port();
        t_dscp();
        t_tags();
        t_vlan();
        t_misc();
        results();
    end
endmodule
